//--- irq_pkg.sv
// Constants, register map and types for the interrupt flag and vector logic
package irq_pkg;

  // APB geometry; register index times four gives the byte address
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          REG_W        = 8;

  // Register indices
  localparam logic [7:0]  IDX_CTRL     = 8'h0b;
  localparam logic [7:0]  IDX_PFLAG    = 8'h0c;
  localparam logic [7:0]  IDX_OPTION   = 8'h81;
  localparam logic [7:0]  IDX_PEN      = 8'h8c;
  localparam logic [7:0]  IDX_STAT     = 8'h90;

  // irq_control_reg fields
  localparam int          GIE_BIT      = 7;
  localparam int          PEIE_BIT     = 6;
  localparam int          TOIE_BIT     = 5;
  localparam int          EXTE_BIT     = 4;
  localparam int          CHGE_BIT     = 3;
  localparam int          TOIF_BIT     = 2;
  localparam int          EXTF_BIT     = 1;
  localparam int          CHGF_BIT     = 0;

  // Peripheral flag / enable field, option field, status fields
  localparam int          CONV_BIT     = 6;
  localparam int          EDGE_SEL_BIT = 6;
  localparam int          STAT_SEQ_BIT = 0;
  localparam int          STAT_ISR_BIT = 1;
  localparam int          STAT_WAKE_BIT = 2;

  // Reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  PFLAG_RST    = 8'h00;
  localparam logic [7:0]  PEN_RST      = 8'h00;
  localparam logic [7:0]  OPTION_RST   = 8'hff;

  // Vector and timer rollover values
  localparam logic [12:0] VECTOR_ADDR  = 13'h0004;
  localparam logic [7:0]  TIMER_MAX    = 8'hff;
  localparam logic [7:0]  TIMER_ZERO   = 8'h00;

  // Instruction cycle timing: four phases per cycle, two dummy cycles
  localparam logic [1:0]  PH_Q1        = 2'h0;
  localparam logic [1:0]  PH_Q4        = 2'h3;
  localparam int          DUMMY_CYC    = 2;
  localparam int          PHASES       = 4;
  localparam logic [3:0]  LOAD_DLY     = 4'(DUMMY_CYC * PHASES);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DUMMY} seq_e;

endpackage

//--- irq_flag_vector.sv
// Interrupt flags, masks and vector sequencing with an APB register slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Four sources: timer, pin edge, change, converter
// - Flags set regardless of any enable
// - Global enable gates every unmasked interrupt
// - Enabled pending flag starts vectoring at the next first phase
// - Reset clears global enable
// - Return instruction sets global enable again
// - Accept clears enable, pushes, loads 0004h
// - Only return address saved by hardware
// - Pin event to vector fetch: 3-4 cycles
// - Latency independent of instruction length
// - Timer rollover FFh to 00h sets flag
// - Timer enable at control bit 5
// - Pin edge polarity from option bit 6
// - Selected pin edge sets control bit 1
// - Control bit 4 masks pin interrupt
// - Enabled pin event wakes from sleep
// - Control bit 3 masks change interrupt
// - Converter flag, enable, peripheral group gate
// - Flags sampled on first clock phase
// - Pin flag sets only in fourth-first span
module irq_flag_vector
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Event sources
  input  wire logic [7:0]        timer_count_reg,
  input  wire logic              conversion_done,
  input  wire logic              ext_irq_pin,
  input  wire logic              change_pin_a,
  input  wire logic              change_pin_b,
  input  wire logic              change_pin_c,
  // Core sequencer
  input  wire logic              return_from_irq_instr,
  input  wire logic              sleep_mode,
  output logic                   first_clock_phase,
  output logic                   irq_take,
  output logic                   vector_load,
  output logic      [12:0]       vector_addr,
  output logic                   wake_req
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0]        phase;
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_prev;
    logic              ext_pend;
    logic [2:0]        chg_s1;
    logic [2:0]        chg_s2;
    logic [2:0]        chg_prev;
    logic [7:0]        tmr_prev;
    logic [7:0]        ctrl;
    logic [7:0]        pflag;
    logic [7:0]        pen;
    logic [7:0]        option;
    seq_e              seq;
    logic [3:0]        dly;
    logic              in_service;
    logic              take;
    logic              load;
    logic              q1;
    logic              wake;
    logic [12:0]       vec;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  localparam state_s ST_RST = '{
    phase: PH_Q1, ext_s1: 1'b0, ext_s2: 1'b0, ext_prev: 1'b0, ext_pend: 1'b0,
    chg_s1: 3'h0, chg_s2: 3'h0, chg_prev: 3'h0, tmr_prev: TIMER_ZERO,
    ctrl: CTRL_RST, pflag: PFLAG_RST, pen: PEN_RST, option: OPTION_RST,
    seq: SEQ_IDLE, dly: 4'h0, in_service: 1'b0, take: 1'b0, load: 1'b0,
    q1: 1'b0, wake: 1'b0, vec: 13'h0000, pready: 1'b0, pslverr: 1'b0,
    prdata: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by read and write paths

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    s = 3'h0;
    if (a[1:0] != 2'h0) begin
      s = 3'h0;
    end else if (a[ADDR_W-1:2] == 10'(IDX_CTRL)) begin
      s = 3'h1;
    end else if (a[ADDR_W-1:2] == 10'(IDX_PFLAG)) begin
      s = 3'h2;
    end else if (a[ADDR_W-1:2] == 10'(IDX_OPTION)) begin
      s = 3'h3;
    end else if (a[ADDR_W-1:2] == 10'(IDX_PEN)) begin
      s = 3'h4;
    end else if (a[ADDR_W-1:2] == 10'(IDX_STAT)) begin
      s = 3'h5;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic       wr_en;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic       ext_edge;
  logic [2:0] chg_hit;
  logic       tmr_roll;
  logic       ctrl_wr;
  logic       pflag_wr;
  logic [7:0] ctrl_set;
  logic       pending;
  logic       any_armed;
  logic       accept;
  logic [7:0] stat_val;

  always_comb begin
    nxt_st = st_ff;
    wr_en  = psel && penable && st_ff.pready && pwrite;
    wsel   = reg_sel(paddr);
    rsel   = reg_sel(paddr);
    ctrl_wr  = wr_en && (wsel == 3'h1);
    pflag_wr = wr_en && (wsel == 3'h2);

    // Instruction cycle phase divider; q1 is the one-cycle phase enable
    nxt_st.phase = st_ff.phase + 2'h1;
    nxt_st.q1    = (st_ff.phase == PH_Q4);

    // Two-stage synchronisers for the asynchronous pins
    nxt_st.ext_s1   = ext_irq_pin;
    nxt_st.ext_s2   = st_ff.ext_s1;
    nxt_st.ext_prev = st_ff.ext_s2;
    nxt_st.chg_s1   = {change_pin_c, change_pin_b, change_pin_a};
    nxt_st.chg_s2   = st_ff.chg_s1;
    nxt_st.chg_prev = st_ff.chg_s2;
    nxt_st.tmr_prev = timer_count_reg;

    // Event detection
    ext_edge = st_ff.option[EDGE_SEL_BIT] ? (st_ff.ext_s2 && !st_ff.ext_prev)
                                          : (!st_ff.ext_s2 && st_ff.ext_prev);
    chg_hit  = st_ff.chg_s2 ^ st_ff.chg_prev;
    tmr_roll = (st_ff.tmr_prev == TIMER_MAX) && (timer_count_reg == TIMER_ZERO);

    // Pin edge waits for the Q4-Q1 window before it may set its flag
    nxt_st.ext_pend = st_ff.ext_pend || ext_edge;
    ctrl_set = 8'h00;
    if ((st_ff.phase == PH_Q4) || (st_ff.phase == PH_Q1)) begin
      ctrl_set[EXTF_BIT] = st_ff.ext_pend || ext_edge;
      nxt_st.ext_pend    = 1'b0;
    end
    ctrl_set[TOIF_BIT] = tmr_roll;
    ctrl_set[CHGF_BIT] = |chg_hit;

    // Control register: software write first, hardware sets win over clears
    if (ctrl_wr) begin
      nxt_st.ctrl = pwdata[7:0];
    end
    nxt_st.ctrl = nxt_st.ctrl | ctrl_set;
    if (pflag_wr) begin
      nxt_st.pflag = pwdata[7:0] & (8'h01 << CONV_BIT);
    end
    if (conversion_done) begin
      nxt_st.pflag[CONV_BIT] = 1'b1;
    end
    if (wr_en && (wsel == 3'h3)) begin
      nxt_st.option = pwdata[7:0];
    end
    if (wr_en && (wsel == 3'h4)) begin
      nxt_st.pen = pwdata[7:0] & (8'h01 << CONV_BIT);
    end

    // Masked sources; global enable applied separately so sleep wake ignores it
    // Exactly four sources feed the request
    any_armed = (st_ff.ctrl[TOIF_BIT] && st_ff.ctrl[TOIE_BIT])
             || (st_ff.ctrl[EXTF_BIT] && st_ff.ctrl[EXTE_BIT])
             || (st_ff.ctrl[CHGF_BIT] && st_ff.ctrl[CHGE_BIT])
             || (st_ff.ctrl[PEIE_BIT] && st_ff.pflag[CONV_BIT]
                 && st_ff.pen[CONV_BIT]);
    pending = st_ff.ctrl[GIE_BIT] && any_armed;
    nxt_st.wake = sleep_mode && any_armed;

    // Recognition only on the first phase, so instruction length never matters
    accept = pending && st_ff.q1 && (st_ff.seq == SEQ_IDLE);
    nxt_st.take = accept;
    nxt_st.load = 1'b0;

    if (return_from_irq_instr) begin
      nxt_st.ctrl[GIE_BIT] = 1'b1;
      nxt_st.in_service    = 1'b0;
    end

    case (st_ff.seq)
      SEQ_IDLE: begin
        if (accept) begin
          // Only the return address is pushed by the core; flags are left alone
          nxt_st.ctrl[GIE_BIT] = 1'b0;
          nxt_st.in_service    = 1'b1;
          nxt_st.seq           = SEQ_DUMMY;
          nxt_st.dly           = LOAD_DLY - 4'h1;
        end
      end
      SEQ_DUMMY: begin
        nxt_st.dly = st_ff.dly - 4'h1;
        if (st_ff.dly == 4'h0) begin
          // Two dummy cycles, then the vector fetch: 3-4 cycles from a pin event
          nxt_st.load = 1'b1;
          nxt_st.vec  = VECTOR_ADDR;
          nxt_st.seq  = SEQ_IDLE;
        end
      end
      default: begin
        nxt_st.seq = SEQ_IDLE;
      end
    endcase

    // APB: answer in the first access cycle, read data captured at setup
    stat_val = 8'h00;
    stat_val[STAT_SEQ_BIT]  = (st_ff.seq != SEQ_IDLE);
    stat_val[STAT_ISR_BIT]  = st_ff.in_service;
    stat_val[STAT_WAKE_BIT] = st_ff.wake;
    nxt_st.pready  = psel && !penable;
    nxt_st.pslverr = psel && !penable && (rsel == 3'h0);
    nxt_st.prdata  = '0;
    if (psel && !penable && !pwrite) begin
      if (rsel == 3'h1) begin
        nxt_st.prdata[7:0] = st_ff.ctrl;
      end else if (rsel == 3'h2) begin
        nxt_st.prdata[7:0] = st_ff.pflag;
      end else if (rsel == 3'h3) begin
        nxt_st.prdata[7:0] = st_ff.option;
      end else if (rsel == 3'h4) begin
        nxt_st.prdata[7:0] = st_ff.pen;
      end else if (rsel == 3'h5) begin
        nxt_st.prdata[7:0] = stat_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata            = st_ff.prdata;
  assign pready            = st_ff.pready;
  assign pslverr           = st_ff.pslverr;
  assign first_clock_phase = st_ff.q1;
  assign irq_take          = st_ff.take;
  assign vector_load       = st_ff.load;
  assign vector_addr       = st_ff.vec;
  assign wake_req          = st_ff.wake;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_take_to_load: assert property (irq_take |-> ##8 vector_load)
    else $error("vector load not eight cycles after take");

  a_take_clears_gie: assert property (irq_take |-> !st_ff.ctrl[GIE_BIT])
    else $error("global enable still set after accept");

  a_take_on_q1: assert property (irq_take |-> $past(st_ff.q1) && $past(pending))
    else $error("interrupt taken outside first phase");

  a_take_needs_gie: assert property (irq_take |-> $past(st_ff.ctrl[GIE_BIT]))
    else $error("interrupt taken with global enable clear");

  a_timer_roll: assert property ((timer_count_reg == TIMER_ZERO)
      && ($past(timer_count_reg) == TIMER_MAX) |=> st_ff.ctrl[TOIF_BIT])
    else $error("timer rollover did not set flag");

  a_return_from_irq_instr_gie: assert property (return_from_irq_instr && !accept
      |=> st_ff.ctrl[GIE_BIT])
    else $error("return did not set global enable");

  a_flag_sticky: assert property (st_ff.ctrl[TOIF_BIT] && !ctrl_wr
      |=> st_ff.ctrl[TOIF_BIT])
    else $error("flag cleared without software write");

  a_ext_window: assert property ($rose(st_ff.ctrl[EXTF_BIT]) && !$past(ctrl_wr)
      |-> ($past(st_ff.phase) == PH_Q4) || ($past(st_ff.phase) == PH_Q1))
    else $error("pin flag set outside Q4-Q1 span");

  a_pending_taken: assert property (pending && st_ff.q1 && (st_ff.seq == SEQ_IDLE)
      |=> irq_take)
    else $error("pending interrupt not taken");

  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");

endmodule

`default_nettype wire

//--- core_model.sv
// Core sequencer model: return stack depth, program counter, return instruction
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // From the interrupt block
  input  wire logic        irq_take,
  input  wire logic        vector_load,
  input  wire logic [12:0] vector_addr,
  // Service routine over; software has already cleared the flags
  input  wire logic        svc_done,
  // To the interrupt block and the bench
  output logic             return_from_irq_instr,
  output logic      [12:0] pc_ff,
  output logic      [3:0]  depth_ff
);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff                 <= 13'h0000;
      depth_ff              <= 4'h0;
      return_from_irq_instr <= 1'b0;
    end else begin
      return_from_irq_instr <= 1'b0;
      if (irq_take) begin
        depth_ff <= depth_ff + 4'h1;
      end
      if (vector_load) begin
        pc_ff <= vector_addr;
      end
      // Return only when asked, so flags are never left set on re-enable
      if (svc_done && depth_ff != 4'h0) begin
        return_from_irq_instr <= 1'b1;
        depth_ff              <= depth_ff - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- interrupt_flag_and_vector_logic_bench.sv
// Self-checking bench for the interrupt flag and vector logic
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_and_vector_logic_bench;
  import irq_pkg::*;
  localparam logic [ADDR_W-1:0] CTRL_A = ADDR_W'(IDX_CTRL) << 2;
  localparam logic [ADDR_W-1:0] PFLG_A = ADDR_W'(IDX_PFLAG) << 2;
  localparam logic [ADDR_W-1:0] OPT_A  = ADDR_W'(IDX_OPTION) << 2;
  localparam logic [ADDR_W-1:0] PEN_A  = ADDR_W'(IDX_PEN) << 2;
  typedef struct {logic [ADDR_W-1:0] a; logic [7:0] w; logic [7:0] r; logic e;} row_s;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rv;
  logic [7:0]        timer_count_reg;
  logic              conversion_done, ext_irq_pin, sleep_mode, svc_done;
  logic              change_pin_a, change_pin_b, change_pin_c, return_from_irq_instr;
  logic              first_clock_phase, irq_take, vector_load, wake_req;
  logic [12:0]       vector_addr, pc_ff;
  logic [3:0]        depth_ff;
  int                err_count = 0, checked = 0, cyc = 0, takes = 0, vls = 0, q1n = 0;
  int                t_take = 0, t_vl = 0, t_evt = 0, q0 = 0;
  row_s rows [9] = '{'{OPT_A, 8'h55, 8'h55, 0}, '{OPT_A, 8'hff, 8'hff, 0},
    '{PEN_A, 8'h40, 8'h40, 0}, '{PEN_A, 8'h00, 8'h00, 0}, '{PFLG_A, 8'h40, 8'h40, 0},
    '{PFLG_A, 8'h00, 8'h00, 0}, '{CTRL_A, 8'h1f, 8'h1f, 0}, '{CTRL_A, 8'h00, 8'h00, 0},
    '{12'h3fc, 8'h5a, 8'h00, 1}};
  ////////////////////////////////////////////////////////////////////////////////
  irq_flag_vector irq_flag_vector_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_count_reg(timer_count_reg),
    .conversion_done(conversion_done), .ext_irq_pin(ext_irq_pin),
    .change_pin_a(change_pin_a), .change_pin_b(change_pin_b), .change_pin_c(change_pin_c),
    .return_from_irq_instr(return_from_irq_instr), .sleep_mode(sleep_mode),
    .first_clock_phase(first_clock_phase), .irq_take(irq_take),
    .vector_load(vector_load), .vector_addr(vector_addr), .wake_req(wake_req));
  core_model core_model_inst (.pclk(pclk), .presetn(presetn), .irq_take(irq_take),
    .vector_load(vector_load), .vector_addr(vector_addr), .svc_done(svc_done),
    .return_from_irq_instr(return_from_irq_instr), .pc_ff(pc_ff), .depth_ff(depth_ff));
  ////////////////////////////////////////////////////////////////////////////////
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (irq_take === 1'b1) begin
      takes  <= takes + 1;
      t_take <= cyc;
    end
    if (vector_load === 1'b1) begin
      vls  <= vls + 1;
      t_vl <= cyc;
    end
    if (first_clock_phase === 1'b1) q1n <= q1n + 1;
    // Whole run needs a few hundred cycles; a hang ends here
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Setup one edge after the previous release, so no signal is driven twice
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers is a failure, not a silent pass
    if (n >= 50) err_count++;
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] x, input logic e);
    apb(1'b0, a, 8'h00);
    cmp({24'h0, rv[7:0]}, {24'h0, x});
    cmp({31'h0, re}, {31'h0, e});
  endtask
  task automatic wait_vl(input int k);
    int n;
    n = 0;
    while (vls < k && n < 100) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic svc();
    svc_done <= 1'b1;
    @(posedge pclk);
    svc_done <= 1'b0;
    idle(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    timer_count_reg = 8'h00; conversion_done = 0; ext_irq_pin = 0; sleep_mode = 0;
    change_pin_a = 0; change_pin_b = 0; change_pin_c = 0; svc_done = 0;
    idle(10);
    presetn <= 1'b1;
    rd(CTRL_A, CTRL_RST, 0);
    rd(OPT_A, OPTION_RST, 0);
    rd(PFLG_A, PFLAG_RST, 0);
    rd(PEN_A, PEN_RST, 0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r, rows[i].e);
    end
    // Difference of two samples avoids racing the counter's own update
    q0 = q1n;
    idle(40);
    cmp(32'(q1n - q0), 32'd10);
    // Timer rollover with everything masked, then enabled
    timer_count_reg <= TIMER_MAX;
    idle(1);
    timer_count_reg <= TIMER_ZERO;
    idle(3);
    rd(CTRL_A, 8'h04, 0);
    wr(CTRL_A, 8'h84);
    idle(20);
    cmp(32'(takes), 32'd0);
    wr(CTRL_A, 8'ha4);
    wait_vl(1);
    cmp(32'(t_vl - t_take), 32'd8);
    cmp({19'h0, pc_ff}, {19'h0, VECTOR_ADDR});
    cmp({28'h0, depth_ff}, 32'd1);
    rd(CTRL_A, 8'h24, 0);
    wr(CTRL_A, 8'h20);
    svc();
    rd(CTRL_A, 8'ha0, 0);
    // Pin edges: rising selected, then falling selected
    wr(CTRL_A, 8'h00);
    ext_irq_pin <= 1'b1;
    idle(12);
    rd(CTRL_A, 8'h02, 0);
    wr(CTRL_A, 8'h00);
    ext_irq_pin <= 1'b0;
    idle(12);
    rd(CTRL_A, 8'h00, 0);
    wr(OPT_A, 8'hbf);
    ext_irq_pin <= 1'b1;
    idle(12);
    rd(CTRL_A, 8'h00, 0);
    ext_irq_pin <= 1'b0;
    idle(12);
    wr(CTRL_A, 8'h12);
    sleep_mode <= 1'b1;
    idle(3);
    cmp({31'h0, wake_req}, 32'd1);
    sleep_mode <= 1'b0;
    ext_irq_pin <= 1'b1;
    wr(CTRL_A, 8'h90);
    ext_irq_pin <= 1'b0;
    t_evt = cyc;
    wait_vl(2);
    cmp(32'(t_vl - t_evt >= 11 && t_vl - t_evt <= 20), 32'd1);
    rd(CTRL_A, 8'h12, 0);
    wr(CTRL_A, 8'h10);
    svc();
    // Each change pin, change enable off while global enable on
    wr(CTRL_A, 8'h80);
    for (int i = 0; i < 3; i++) begin
      {change_pin_c, change_pin_b, change_pin_a} <=
        {change_pin_c, change_pin_b, change_pin_a} ^ (3'b001 << i);
      idle(8);
      rd(CTRL_A, 8'h81, 0);
      wr(CTRL_A, 8'h80);
    end
    cmp(32'(takes), 32'd2);
    // Converter flag gated by its enable, with the group enable already set
    conversion_done <= 1'b1;
    idle(1);
    conversion_done <= 1'b0;
    rd(PFLG_A, 8'h40, 0);
    wr(CTRL_A, 8'hc0);
    idle(12);
    cmp(32'(takes), 32'd2);
    wr(PEN_A, 8'h40);
    wait_vl(3);
    cmp(32'(takes), 32'd3);
    wr(PFLG_A, 8'h00);
    svc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
